// ### dv/pattern_sequencer_tb.sv
// Purpose: Self-checking bench of the internal pattern sequencer.
// Assumes: Avalon-MM register slave answers with one low waitrequest cycle.
// Notes: Intervals are set so that a frame outlasts the frame pulse.
`timescale 1ns/1ps
`include "seq_defs.svh"
module pattern_sequencer_tb;
  typedef struct {
    logic        w;
    logic [7:0]  a;
    logic [3:0]  be;
    logic [31:0] d;
    logic [31:0] e;
  } row_t;
  logic        CLK = 1'b0;
  logic        RESET = 1'b1;
  logic        AVS_READ = 1'b0;
  logic        AVS_WRITE = 1'b0;
  logic [7:0]  AVS_ADDRESS = 8'h00;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [3:0]  AVS_BYTEENABLE = 4'hf;
  logic        trig_en = 1'b0;
  logic        force_trig = 1'b0;
  logic [31:0] AVS_READDATA, FLASH_RDATA, PATTERN_LINE, rd, cur_line;
  logic [23:0] FLASH_ADDR;
  logic [2:0]  ILLUM_EN, cur_ill;
  logic        AVS_WAITREQUEST, FLASH_REQ, FLASH_ACK, PATTERN_ADVANCE_IN, PATTERN_READY;
  logic        FRAME_SET_PULSE_OUT, EXPOSURE_ACTIVE_OUT, ROW_REPLICATE, fsp_d;
  int          error_cnt = 0, tests_run = 0, rises = 0, fw = 0, lit = 0, ex = 0, rdy_bad = 0;
  int          lit_q[$], ex_q[$], w_q[$];
  logic [31:0] line_q[$];
  logic [2:0]  ill_q[$];
  row_t rows [0:15] = '{
    '{0, 8'h00, 4'hf, 32'h0, 32'h40}, '{0, 8'h04, 4'hf, 32'h0, 32'h64},
    '{0, 8'h08, 4'hf, 32'h0, 32'h64}, '{0, 8'h0c, 4'hf, 32'h0, 32'h64},
    '{0, 8'h10, 4'hf, 32'h0, 32'h0}, '{0, 8'h14, 4'hf, 32'h0, 32'h0},
    '{0, 8'h18, 4'hf, 32'h0, 32'h0}, '{0, 8'h1c, 4'hf, 32'h0, 32'h0},
    '{1, 8'h04, 4'hf, 32'hffff0028, 32'h28}, '{1, 8'h08, 4'hf, 32'h64, 32'h64},
    '{1, 8'h0c, 4'h1, 32'hab3c, 32'h3c}, '{1, 8'h10, 4'hf, 32'h4, 32'h4},
    '{1, 8'h14, 4'hf, 32'h32, 32'h32}, '{1, 8'h18, 4'hf, 32'hf, 32'h0},
    '{1, 8'h20, 4'hf, 32'h5a, 32'h0}, '{1, 8'h00, 4'hf, 32'h38, 32'h38}};

  always #20 CLK = ~CLK;

  pattern_sequencer dut (
    .CLK(CLK), .RESET(RESET), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .FLASH_REQ(FLASH_REQ),
    .FLASH_ADDR(FLASH_ADDR), .FLASH_RDATA(FLASH_RDATA), .FLASH_ACK(FLASH_ACK),
    .PATTERN_ADVANCE_IN(PATTERN_ADVANCE_IN), .PATTERN_READY(PATTERN_READY),
    .FRAME_SET_PULSE_OUT(FRAME_SET_PULSE_OUT), .EXPOSURE_ACTIVE_OUT(EXPOSURE_ACTIVE_OUT),
    .ILLUM_EN(ILLUM_EN), .PATTERN_LINE(PATTERN_LINE), .ROW_REPLICATE(ROW_REPLICATE));

  seq_far_side far (
    .CLK(CLK), .RESET(RESET), .FLASH_REQ(FLASH_REQ), .FLASH_ADDR(FLASH_ADDR),
    .FLASH_RDATA(FLASH_RDATA), .FLASH_ACK(FLASH_ACK), .PATTERN_READY(PATTERN_READY),
    .trig_en(trig_en), .force_trig(force_trig), .PATTERN_ADVANCE_IN(PATTERN_ADVANCE_IN));

  ////////////////////////////////////////////////////////////////////////////////
  // Each lit run is one slot; its length, lit pattern and exposure output time are kept.
  always @(posedge CLK)
  begin
    fsp_d <= FRAME_SET_PULSE_OUT;
    if (FRAME_SET_PULSE_OUT === 1'b1 && fsp_d !== 1'b1)
      rises <= rises + 1;
    fw <= (FRAME_SET_PULSE_OUT === 1'b1) ? fw + 1 : 0;
    if (FRAME_SET_PULSE_OUT !== 1'b1 && fw != 0)
      w_q.push_back(fw);
    if (ILLUM_EN !== 3'h0 && PATTERN_READY !== 1'b0)
      rdy_bad <= rdy_bad + 1;
    ex <= (EXPOSURE_ACTIVE_OUT === 1'b1) ? ex + 1 : ex;
    if (ILLUM_EN !== 3'h0)
    begin
      lit      <= lit + 1;
      cur_line <= PATTERN_LINE;
      cur_ill  <= ILLUM_EN;
    end
    else if (lit != 0)
    begin
      lit_q.push_back(lit);
      ex_q.push_back(ex);
      line_q.push_back(cur_line);
      ill_q.push_back(cur_ill);
      lit <= 0;
      ex  <= 0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp_w(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cmp_i(input string n, input int e, input int g);
    tests_run++;
    if (g != e)
    begin
      error_cnt++;
      $display("BAD %s expected %0d seen %0d", n, e, g);
    end
  endtask

  // The gap edge at entry keeps a released strobe from being raised in the same step.
  task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] be,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge CLK);
    AVS_ADDRESS    <= a;
    AVS_WRITEDATA  <= d;
    AVS_BYTEENABLE <= be;
    AVS_WRITE      <= w;
    AVS_READ       <= ~w;
    do
    begin
      @(posedge CLK);
    end
    while (AVS_WAITREQUEST !== 1'b0);
    r = AVS_READDATA;
    AVS_READ  <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask

  task automatic slots(input int n);
    int t;
    t = 0;
    while (lit_q.size() < n && t < 5000)
    begin
      @(posedge CLK);
      t++;
    end
  endtask

  task automatic clear_mon();
    lit_q.delete();
    ex_q.delete();
    line_q.delete();
    ill_q.delete();
    w_q.delete();
  endtask

  task automatic chk_slots(input int n, input int cnt, input int expo, input int exv);
    cmp_i("slots", n, (lit_q.size() < n) ? lit_q.size() : n);
    for (int k = 0; k < n && k < lit_q.size(); k++)
    begin
      cmp_i("lit length", expo, lit_q[k]);
      cmp_i("exposure out length", exv, ex_q[k]);
      cmp_w("illuminator", 32'h1, {29'h0, ill_q[k]});
      cmp_w("line", far.mem[1 + k % cnt], line_q[k]);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge CLK);
    error_cnt++;
    $display("BAD watchdog expected end seen hang");
    summarize();
  end

  initial
  begin
    int t;
    int base;
    int bad0;
    t = 0;
    repeat (20) @(posedge CLK);
    RESET <= 1'b0;
    foreach (rows[i])
    begin
      if (rows[i].w)
        bus(1'b1, rows[i].a, rows[i].be, rows[i].d, rd);
      bus(1'b0, rows[i].a, 4'hf, 32'h0, rd);
      cmp_w("register", rows[i].e, rd);
    end
    @(negedge CLK);
    cmp_w("row replicate", 32'h1, {31'h0, ROW_REPLICATE});
    $display("test registers done");
    far.mem[0] = 32'hffffffe3;
    far.mem[1] = 32'ha5a50001;
    far.mem[2] = 32'h0f0f0002;
    far.mem[3] = 32'h3c3c0003;
    clear_mon();
    base = rises;
    bus(1'b1, 8'h00, 4'hf, 32'h12, rd);
    while (FLASH_REQ !== 1'b1 && t < 4)
    begin
      @(negedge CLK);
      t++;
    end
    cmp_w("flash request", 32'h1, {31'h0, FLASH_REQ});
    cmp_w("flash address", 32'h0, {8'h0, FLASH_ADDR});
    slots(6);
    chk_slots(6, 3, 100, 90);
    cmp_i("frame pulses", 2, rises - base);
    cmp_i("frame pulse width", `SEQ_FRAME_PULSE_CYC, w_q[0]);
    bus(1'b0, 8'h18, 4'hf, 32'h0, rd);
    cmp_w("pattern count", 32'h3, (rd >> 8) & 32'h1f);
    $display("test free running done");
    bus(1'b1, 8'h00, 4'hf, 32'h14, rd);
    base = rises;
    @(posedge CLK);
    force_trig <= 1'b1;
    @(posedge CLK);
    force_trig <= 1'b0;
    repeat (20) @(posedge CLK);
    bus(1'b0, 8'h18, 4'hf, 32'h0, rd);
    cmp_w("idle state", 32'h0, rd & 32'h1f);
    cmp_i("pulses in idle", 0, rises - base);
    $display("test stop done");
    far.mem[0] = 32'h2;
    bus(1'b1, 8'h08, 4'hf, 32'hc8, rd);
    bus(1'b1, 8'h14, 4'hf, 32'ha, rd);
    clear_mon();
    base = rises;
    bad0 = rdy_bad;
    bus(1'b1, 8'h00, 4'hf, 32'h13, rd);
    t = 0;
    while (PATTERN_READY !== 1'b1 && t < 200)
    begin
      @(negedge CLK);
      t++;
    end
    bus(1'b0, 8'h18, 4'hf, 32'h0, rd);
    cmp_w("wait state ready", 32'h13, rd & 32'h1f);
    cmp_w("pattern count", 32'h2, (rd >> 8) & 32'h1f);
    trig_en <= 1'b1;
    slots(1);
    t = 0;
    while (ILLUM_EN === 3'h0 && t < 400)
    begin
      @(posedge CLK);
      t++;
    end
    force_trig <= 1'b1;
    @(posedge CLK);
    force_trig <= 1'b0;
    slots(4);
    trig_en <= 1'b0;
    chk_slots(4, 2, 200, 190);
    cmp_i("ready during slot", 0, rdy_bad - bad0);
    cmp_i("set pulses", 2, rises - base);
    cmp_i("set pulse width", `SEQ_FRAME_PULSE_CYC, w_q[0]);
    $display("test trigger in done");
    RESET <= 1'b1;
    repeat (3) @(posedge CLK);
    RESET <= 1'b0;
    @(negedge CLK);
    cmp_w("outputs after reset", 32'h0, {24'h0, FLASH_REQ, PATTERN_READY, FRAME_SET_PULSE_OUT,
          EXPOSURE_ACTIVE_OUT, ILLUM_EN, ROW_REPLICATE});
    cmp_w("line after reset", 32'h0, PATTERN_LINE);
    bus(1'b0, 8'h04, 4'hf, 32'h0, rd);
    cmp_w("pre dark after reset", 32'h64, rd);
    bus(1'b0, 8'h00, 4'hf, 32'h0, rd);
    cmp_w("control after reset", 32'h40, rd);
    $display("test second reset done");
    summarize();
  end
endmodule

// ### dv/seq_far_side.sv
// Purpose: Flash reader and camera model on the far side of the pattern sequencer.
// Assumes: One acknowledge per word request; the trigger is edge sensitive.
// Notes: The trigger is raised only on ready, unless force_trig orders a stray one.
`timescale 1ns/1ps
module seq_far_side (
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic        FLASH_REQ,
  input  wire logic [23:0] FLASH_ADDR,
  output logic      [31:0] FLASH_RDATA,
  output logic             FLASH_ACK,
  input  wire logic        PATTERN_READY,
  input  wire logic        trig_en,
  input  wire logic        force_trig,
  output logic             PATTERN_ADVANCE_IN
);
  logic [31:0] mem [0:31];
  int          wait_c = 0;
  int          hold   = 0;
  logic        slow   = 1'b0;
  logic        go;
  logic        fire;

  ////////////////////////////////////////////////////////////////////////////////
  // Acknowledges alternate between a prompt and a slow answer.
  assign go   = !RESET && FLASH_REQ && !FLASH_ACK && wait_c >= (slow ? 3 : 1);
  assign fire = !RESET && hold == 0 && (force_trig || (trig_en && PATTERN_READY));

  initial
  begin
    FLASH_ACK          = 1'b0;
    FLASH_RDATA        = 32'h0;
    PATTERN_ADVANCE_IN = 1'b0;
  end

  // Data lines toggle between acknowledges so that stale data cannot pass as valid.
  always @(posedge CLK)
  begin
    FLASH_ACK   <= go;
    FLASH_RDATA <= go ? mem[FLASH_ADDR[4:0]] : ~FLASH_RDATA;
    wait_c      <= (RESET || go) ? 0 : (FLASH_REQ && !FLASH_ACK) ? wait_c + 1 : 0;
    slow        <= go ? ~slow : slow;
  end

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge CLK)
  begin
    hold               <= RESET ? 0 : (hold != 0) ? hold - 1 : fire ? 3 : 0;
    PATTERN_ADVANCE_IN <= RESET ? 1'b0 : fire ? 1'b1 :
                          (hold == 1) ? 1'b0 : PATTERN_ADVANCE_IN;
  end
endmodule

// ### inc/seq_defs.svh
// Purpose: Constants of the internal one-dimensional pattern sequencer.
// Assumes: 25 MHz controller clock; 32-bit Avalon-MM register slave.
// Notes: Offsets are byte addresses; every register is one aligned word.
// Function
// - Only 1D patterns are shown: one stored line replicated along rows or columns.
// - Pattern lines are stored in flash beforehand and shown after one host command.
// - Display is paced either free running or by external trigger, chosen by configuration.
// - In free running, start copies flash into internal memory and then display begins.
// - All patterns of one free-running frame use the same pre-dark, exposure and post-dark.
// - The configured illuminator is switched on during each pattern.
// - In free running the frame pulse is high, of minimum width, delayed from frame sync.
// - In free running the exposure output is high during exposure, delayed from slot start.
// - The internal frame period follows from the pattern set stored in flash.
// - In trigger mode the ready output is high while a trigger can be accepted.
// - In trigger mode the set pulse is high, of minimum width, delayed from trigger.
// - In trigger mode the exposure output is high in exposure, delayed from exposure start.
// - The trigger input is honoured only while waiting in internal display, else ignored.
// - The first trigger output fires at the start of each group of patterns.
// - Each slot runs pre-dark unlit, exposure lit with the pattern, then post-dark unlit.
`ifndef SEQ_DEFS_SVH
`define SEQ_DEFS_SVH

`define SEQ_REG_CTRL       8'h00
`define SEQ_REG_PRE_DARK   8'h04
`define SEQ_REG_EXPOSURE   8'h08
`define SEQ_REG_POST_DARK  8'h0c
`define SEQ_REG_FRAME_DLY  8'h10
`define SEQ_REG_EXPO_DLY   8'h14
`define SEQ_REG_STATUS     8'h18

`define SEQ_CTRL_TRIG_BIT  0
`define SEQ_CTRL_START_BIT 1
`define SEQ_CTRL_STOP_BIT  2
`define SEQ_CTRL_ROW_BIT   3
`define SEQ_CTRL_ILL_LSB   4
`define SEQ_CTRL_ILL_MSB   6

`define SEQ_STAT_STATE_LSB 0
`define SEQ_STAT_STATE_MSB 3
`define SEQ_STAT_READY_BIT 4
`define SEQ_STAT_CNT_LSB   8
`define SEQ_STAT_IDX_LSB   16

`define SEQ_RST_ILLUM      3'h4
`define SEQ_RST_INTERVAL   16'h0064

`define SEQ_CLK_HZ         25000000
`define SEQ_FRAME_PULSE_US 20
`define SEQ_US_PER_S       1000000
`define SEQ_FRAME_PULSE_CYC \
  ((`SEQ_FRAME_PULSE_US * `SEQ_CLK_HZ + `SEQ_US_PER_S - 1) / `SEQ_US_PER_S)

`endif

// ### inc/seq_pkg.sv
// Purpose: Types shared by the pattern sequencer files.
// Assumes: Nothing beyond the constants header.
// Notes: State order is visible in the status register.
package seq_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOAD_HDR,
    ST_LOAD_PAT,
    ST_WAIT_TRIG,
    ST_PRE,
    ST_EXPO,
    ST_POST
  } seq_state_t;

endpackage

// ### logic/pattern_sequencer.sv
// Purpose: Internal pattern mode sequencer with Avalon-MM register slave.
// Assumes: Flash reader answers each word request with one FLASH_ACK pulse.
// Notes: Flash word 0 holds the pattern count, words 1..count hold lines.
//
// The implementer's own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`include "seq_defs.svh"
module pattern_sequencer #(
  parameter int          LINE_W     = 32,
  parameter int          DW         = 4,
  parameter int          TW         = 16,
  parameter logic [23:0] FLASH_BASE = 24'h000000
) (
  input  wire logic              CLK,
  input  wire logic              RESET,
  input  wire logic [7:0]        AVS_ADDRESS,
  input  wire logic              AVS_READ,
  input  wire logic              AVS_WRITE,
  input  wire logic [31:0]       AVS_WRITEDATA,
  input  wire logic [3:0]        AVS_BYTEENABLE,
  output logic      [31:0]       AVS_READDATA,
  output logic                   AVS_WAITREQUEST,
  output logic                   FLASH_REQ,
  output logic      [23:0]       FLASH_ADDR,
  input  wire logic [LINE_W-1:0] FLASH_RDATA,
  input  wire logic              FLASH_ACK,
  input  wire logic              PATTERN_ADVANCE_IN,
  output logic                   PATTERN_READY,
  output logic                   FRAME_SET_PULSE_OUT,
  output logic                   EXPOSURE_ACTIVE_OUT,
  output logic      [2:0]        ILLUM_EN,
  output logic      [LINE_W-1:0] PATTERN_LINE,
  output logic                   ROW_REPLICATE
);
  import seq_pkg::*;

  localparam int         DEPTH   = 1 << DW;
  localparam logic [DW:0] DEPTH_N = DEPTH[DW:0];
  localparam logic [DW:0] ONE_N   = (DW+1)'(1);
  localparam logic [9:0]  PW_CYC  = 10'(`SEQ_FRAME_PULSE_CYC);

  typedef struct packed {
    seq_state_t        st;
    logic              trig_mode;
    logic              row_rep;
    logic [2:0]        illum;
    logic [TW-1:0]     pre;
    logic [TW-1:0]     expo;
    logic [TW-1:0]     post;
    logic [TW-1:0]     d1;
    logic [TW-1:0]     d2;
    logic [TW-1:0]     pre_s;
    logic [TW-1:0]     expo_s;
    logic [TW-1:0]     post_s;
    logic [DW:0]       count;
    logic [DW-1:0]     idx;
    logic [DW:0]       ld_idx;
    logic [TW-1:0]     ph;
    logic [TW-1:0]     slot_t;
    logic [TW-1:0]     fd_cnt;
    logic              fd_run;
    logic [9:0]        pw;
    logic              trig_prev;
    logic              wreq;
    logic [31:0]       rdata;
    logic              flash_req;
    logic [23:0]       flash_addr;
    logic              ready;
    logic              frame_out;
    logic              expo_out;
    logic [2:0]        led;
    logic [LINE_W-1:0] line;
  } seq_t;

  seq_t s_q;
  seq_t s_d;

  logic [LINE_W-1:0] rd_line;
  logic              mem_we;
  logic              bus_wr;
  logic              ctrl_wr;
  logic              start_cmd;
  logic              stop_cmd;
  logic              trig_edge;

  ////////////////////////////////////////////////////////////////////////////////
  // Register access helpers.

  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] reg_read(input logic [7:0] a, input seq_t v);
    logic [31:0] r;
    r = 32'h0;
    case (a)
      `SEQ_REG_CTRL:
      begin
        r[`SEQ_CTRL_TRIG_BIT]                   = v.trig_mode;
        r[`SEQ_CTRL_ROW_BIT]                    = v.row_rep;
        r[`SEQ_CTRL_ILL_MSB:`SEQ_CTRL_ILL_LSB]  = v.illum;
      end
      `SEQ_REG_PRE_DARK:  r[TW-1:0] = v.pre;
      `SEQ_REG_EXPOSURE:  r[TW-1:0] = v.expo;
      `SEQ_REG_POST_DARK: r[TW-1:0] = v.post;
      `SEQ_REG_FRAME_DLY: r[TW-1:0] = v.d1;
      `SEQ_REG_EXPO_DLY:  r[TW-1:0] = v.d2;
      `SEQ_REG_STATUS:
      begin
        r[`SEQ_STAT_STATE_MSB:`SEQ_STAT_STATE_LSB] = {1'b0, v.st};
        r[`SEQ_STAT_READY_BIT]                     = v.ready;
        r[`SEQ_STAT_CNT_LSB +: DW+1]               = v.count;
        r[`SEQ_STAT_IDX_LSB +: DW]                 = v.idx;
      end
      default:            r = 32'h0;
    endcase
    return r;
  endfunction

  // A write takes effect at the edge where the master sees waitrequest low.
  assign bus_wr    = !s_q.wreq && AVS_WRITE;
  assign ctrl_wr   = bus_wr && (AVS_ADDRESS == `SEQ_REG_CTRL) && AVS_BYTEENABLE[0];
  assign start_cmd = ctrl_wr && AVS_WRITEDATA[`SEQ_CTRL_START_BIT];
  assign stop_cmd  = ctrl_wr && AVS_WRITEDATA[`SEQ_CTRL_STOP_BIT];
  assign trig_edge = PATTERN_ADVANCE_IN && !s_q.trig_prev;
  assign mem_we    = (s_q.st == ST_LOAD_PAT) && FLASH_ACK;

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb
  begin
    logic [31:0]   wv;
    logic          fsync;
    logic          done;
    logic [DW:0]   nxt;
    logic [DW:0]   hdr;
    logic [TW:0]   ref_t;
    wv    = be_merge(reg_read(AVS_ADDRESS, s_q), AVS_WRITEDATA, AVS_BYTEENABLE);
    fsync = 1'b0;
    done  = 1'b0;
    nxt   = {1'b0, s_q.idx} + ONE_N;
    hdr   = FLASH_RDATA[DW:0];
    ref_t = '0;
    s_d   = s_q;

    // Slave answers after one wait cycle; read data is latched with the drop.
    if (s_q.wreq && (AVS_READ || AVS_WRITE))
    begin
      s_d.wreq  = 1'b0;
      s_d.rdata = reg_read(AVS_ADDRESS, s_q);
    end
    else if (!s_q.wreq)
    begin
      s_d.wreq = 1'b1;
    end
    if (bus_wr)
    begin
      case (AVS_ADDRESS)
        `SEQ_REG_CTRL:
        begin
          s_d.trig_mode = wv[`SEQ_CTRL_TRIG_BIT];
          s_d.row_rep   = wv[`SEQ_CTRL_ROW_BIT];
          s_d.illum     = wv[`SEQ_CTRL_ILL_MSB:`SEQ_CTRL_ILL_LSB];
        end
        `SEQ_REG_PRE_DARK:  s_d.pre  = wv[TW-1:0];
        `SEQ_REG_EXPOSURE:  s_d.expo = wv[TW-1:0];
        `SEQ_REG_POST_DARK: s_d.post = wv[TW-1:0];
        `SEQ_REG_FRAME_DLY: s_d.d1   = wv[TW-1:0];
        `SEQ_REG_EXPO_DLY:  s_d.d2   = wv[TW-1:0];
        default:            s_d.wreq = 1'b1;
      endcase
    end

    s_d.trig_prev = PATTERN_ADVANCE_IN;
    if (s_q.st == ST_PRE || s_q.st == ST_EXPO || s_q.st == ST_POST)
    begin
      s_d.ph     = s_q.ph + 1'b1;
      s_d.slot_t = s_q.slot_t + 1'b1;
    end

    case (s_q.st)
      ST_IDLE:
      begin
        if (start_cmd)
        begin
          s_d.st         = ST_LOAD_HDR;
          s_d.flash_req  = 1'b1;
          s_d.flash_addr = FLASH_BASE;
        end
      end
      ST_LOAD_HDR:
      begin
        if (FLASH_ACK)
        begin
          // The set's own count fixes the frame length.
          s_d.count      = (hdr == '0) ? ONE_N : ((hdr > DEPTH_N) ? DEPTH_N : hdr);
          s_d.ld_idx     = '0;
          s_d.flash_addr = s_q.flash_addr + 1'b1;
          s_d.st         = ST_LOAD_PAT;
        end
      end
      ST_LOAD_PAT:
      begin
        if (FLASH_ACK)
        begin
          s_d.ld_idx     = s_q.ld_idx + ONE_N;
          s_d.flash_addr = s_q.flash_addr + 1'b1;
          if (s_q.ld_idx + ONE_N == s_q.count)
          begin
            s_d.flash_req = 1'b0;
            s_d.idx       = '0;
            s_d.st        = s_q.trig_mode ? ST_WAIT_TRIG : ST_PRE;
            fsync         = !s_q.trig_mode;
          end
        end
      end
      ST_WAIT_TRIG:
      begin
        // Only this state looks at the trigger.
        if (trig_edge)
        begin
          s_d.st = ST_PRE;
          fsync  = (s_q.idx == '0);
        end
      end
      ST_PRE:
      begin
        if ({1'b0, s_q.ph} + 1'b1 >= {1'b0, s_q.pre_s})
        begin
          s_d.st = ST_EXPO;
          s_d.ph = '0;
        end
      end
      ST_EXPO:
      begin
        if ({1'b0, s_q.ph} + 1'b1 >= {1'b0, s_q.expo_s})
        begin
          s_d.st = ST_POST;
          s_d.ph = '0;
        end
      end
      ST_POST:
      begin
        done = ({1'b0, s_q.ph} + 1'b1 >= {1'b0, s_q.post_s});
        if (done)
        begin
          s_d.idx = (nxt == s_q.count) ? '0 : nxt[DW-1:0];
          // Ready returns only once the whole slot is over.
          s_d.st  = s_q.trig_mode ? ST_WAIT_TRIG : ST_PRE;
          fsync   = !s_q.trig_mode && (nxt == s_q.count);
        end
      end
      default:
      begin
        s_d.st = ST_IDLE;
      end
    endcase

    if (s_d.st == ST_PRE && s_q.st != ST_PRE)
    begin
      s_d.ph     = '0;
      s_d.slot_t = '0;
    end
    if (fsync)
    begin
      // Intervals are frozen for the whole group.
      s_d.pre_s  = s_q.pre;
      s_d.expo_s = s_q.expo;
      s_d.post_s = s_q.post;
    end
    if (stop_cmd)
    begin
      s_d.st        = ST_IDLE;
      s_d.flash_req = 1'b0;
    end

    // Frame or set pulse: delay from sync, then a fixed minimum width.
    if (s_q.pw != '0)
    begin
      s_d.pw = s_q.pw - 1'b1;
    end
    if (fsync)
    begin
      s_d.fd_run = 1'b1;
      s_d.fd_cnt = '0;
    end
    else if (s_q.fd_run)
    begin
      if (s_q.fd_cnt >= s_q.d1)
      begin
        s_d.fd_run = 1'b0;
        s_d.pw     = PW_CYC;
      end
      else
      begin
        s_d.fd_cnt = s_q.fd_cnt + 1'b1;
      end
    end
    s_d.frame_out = (s_q.pw != '0);

    // Outputs line up with the state that they belong to.
    s_d.ready = (s_d.st == ST_WAIT_TRIG);
    s_d.led   = (s_d.st == ST_EXPO) ? s_q.illum : 3'h0;
    s_d.line  = (s_d.st == ST_EXPO) ? rd_line : '0;
    // Free running counts the delay from slot start, trigger mode from exposure start.
    ref_t = s_d.trig_mode ? ({1'b0, s_d.pre_s} + {1'b0, s_d.d2}) : {1'b0, s_d.d2};
    s_d.expo_out = ((s_d.st == ST_EXPO) || (!s_d.trig_mode && s_d.st == ST_PRE)) &&
                   ({1'b0, s_d.slot_t} >= ref_t);
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      s_q          <= '0;
      s_q.st       <= ST_IDLE;
      s_q.wreq     <= 1'b1;
      s_q.illum    <= `SEQ_RST_ILLUM;
      s_q.pre      <= `SEQ_RST_INTERVAL;
      s_q.expo     <= `SEQ_RST_INTERVAL;
      s_q.post     <= `SEQ_RST_INTERVAL;
      s_q.pre_s    <= `SEQ_RST_INTERVAL;
      s_q.expo_s   <= `SEQ_RST_INTERVAL;
      s_q.post_s   <= `SEQ_RST_INTERVAL;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  pattern_store #(
    .LINE_W (LINE_W),
    .DW     (DW)
  ) u_store (
    .clk     (CLK),
    .reset   (RESET),
    .wr_en   (mem_we),
    .wr_idx  (s_q.ld_idx[DW-1:0]),
    .wr_data (FLASH_RDATA),
    .rd_idx  (s_q.idx),
    .rd_data (rd_line)
  );

  assign AVS_READDATA        = s_q.rdata;
  assign AVS_WAITREQUEST     = s_q.wreq;
  assign FLASH_REQ           = s_q.flash_req;
  assign FLASH_ADDR          = s_q.flash_addr;
  assign PATTERN_READY       = s_q.ready;
  assign FRAME_SET_PULSE_OUT = s_q.frame_out;
  assign EXPOSURE_ACTIVE_OUT = s_q.expo_out;
  assign ILLUM_EN            = s_q.led;
  assign PATTERN_LINE        = s_q.line;
  assign ROW_REPLICATE       = s_q.row_rep;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_ready_state: assert property (@(posedge CLK) disable iff (RESET)
    PATTERN_READY == (s_q.st == ST_WAIT_TRIG)) else $error("ready not tied to wait state");
  a_ready_drop: assert property (@(posedge CLK) disable iff (RESET)
    (s_q.st == ST_WAIT_TRIG && trig_edge && !stop_cmd) |=> !PATTERN_READY && s_q.st == ST_PRE)
    else $error("ready kept after trigger");
  a_trig_ignore: assert property (@(posedge CLK) disable iff (RESET)
    (s_q.st == ST_IDLE && PATTERN_ADVANCE_IN && !start_cmd) |=> s_q.st == ST_IDLE)
    else $error("trigger acted outside display");
  a_start_load: assert property (@(posedge CLK) disable iff (RESET)
    (s_q.st == ST_IDLE && start_cmd && !stop_cmd) |=> s_q.st == ST_LOAD_HDR && FLASH_REQ)
    else $error("start did not begin loading");
  a_illum_expo: assert property (@(posedge CLK) disable iff (RESET)
    (ILLUM_EN != 3'h0) |-> s_q.st == ST_EXPO) else $error("light on outside exposure");
  a_dark_line: assert property (@(posedge CLK) disable iff (RESET)
    (s_q.st != ST_EXPO) |-> PATTERN_LINE == '0) else $error("pattern shown while dark");
  a_slot_order: assert property (@(posedge CLK) disable iff (RESET)
    (s_q.st == ST_POST) |-> ($past(s_q.st) == ST_EXPO || $past(s_q.st) == ST_POST))
    else $error("post-dark not after exposure");
  a_pulse_start: assert property (@(posedge CLK) disable iff (RESET)
    $rose(FRAME_SET_PULSE_OUT) |-> s_q.pw == PW_CYC - 10'h001)
    else $error("frame pulse width load wrong");
  a_pulse_hold: assert property (@(posedge CLK) disable iff (RESET)
    (FRAME_SET_PULSE_OUT && s_q.pw != '0) |=> FRAME_SET_PULSE_OUT)
    else $error("frame pulse ended early");
  a_expo_trig: assert property (@(posedge CLK) disable iff (RESET)
    (s_q.trig_mode && EXPOSURE_ACTIVE_OUT) |-> s_q.st == ST_EXPO)
    else $error("exposure output outside exposure");
  a_expo_free: assert property (@(posedge CLK) disable iff (RESET)
    EXPOSURE_ACTIVE_OUT |-> (s_q.st == ST_PRE || s_q.st == ST_EXPO))
    else $error("exposure output after exposure");

endmodule

// ### logic/pattern_store.sv
// Purpose: Flip-flop store of one-dimensional pattern lines.
// Assumes: One write port used during loading, one combinational read port.
// Notes: Contents clear on reset; a set must be loaded again after it.
`timescale 1ns/1ps
module pattern_store #(
  parameter int LINE_W = 32,
  parameter int DW     = 4
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              wr_en,
  input  wire logic [DW-1:0]     wr_idx,
  input  wire logic [LINE_W-1:0] wr_data,
  input  wire logic [DW-1:0]     rd_idx,
  output logic      [LINE_W-1:0] rd_data
);
  import seq_pkg::*;

  localparam int DEPTH = 1 << DW;

  typedef struct packed {
    logic [DEPTH-1:0][LINE_W-1:0] mem;
  } store_t;

  store_t s_q;
  store_t s_d;

  always_comb
  begin
    s_d = s_q;
    if (wr_en)
    begin
      s_d.mem[wr_idx] = wr_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign rd_data = s_q.mem[rd_idx];

endmodule
